/* design/level_sync.v */
// Two-flop synchroniser for a level arriving from outside the clock domain
module level_sync #(
  parameter RESET_LEVEL = 1'b0
) (
  input  wire aclk,
  input  wire aresetn,
  input  wire async_in,
  output reg  sync_out
);

  reg stage1_q;

  // First stage feeds only the second stage to keep metastability contained
  always @(posedge aclk) begin
    if (!aresetn) begin
      stage1_q <= RESET_LEVEL;
      sync_out <= RESET_LEVEL;
    end else begin
      stage1_q <= async_in;
      sync_out <= stage1_q;
    end
  end

endmodule

/* design/pc_seq_map.vh */
// Register offsets, field layout, reset values and opcodes of the program counter sequencer
`ifndef PC_SEQ_MAP_VH
`define PC_SEQ_MAP_VH

// ==========================================================
// Register indices (byte address = index * 4)
`define IDX_TABLE_DATA_HIGH    8'h94
`define IDX_TABLE_POINTER_HIGH 8'h9a
`define IDX_TABLE_POINTER_LOW  8'h9b
`define IDX_PC_HIGH_LATCH      8'h0a
`define IDX_PC_LOW_BYTE        8'h02
`define IDX_STATUS             8'hc0
`define IDX_CONTROL            8'hc1

// ==========================================================
// Field positions
`define STAT_TO_BIT       0
`define STAT_PD_BIT       1
`define STAT_CAUSE_LSB    2
`define STAT_CAUSE_MSB    4
`define STAT_PC_LSB       8
`define STAT_PC_MSB       18
`define CTRL_GIE_BIT      0

// ==========================================================
// Reset values and vectors
`define PC_RESET_VECTOR   11'h000
`define PC_IRQ_VECTOR     11'h004
`define PC_LAST_WORD      11'h7ff
`define PTR_RESET         8'h00
`define LATCH_RESET       3'h0
`define CAUSE_POWER_ON    3'h1
`define CAUSE_WATCHDOG    3'h2
`define CAUSE_LOW_SUPPLY  3'h4

// ==========================================================
// Core command opcodes
`define OP_ADVANCE        3'h0
`define OP_JUMP           3'h1
`define OP_ADD_PC_LOW     3'h2
`define OP_WRITE_PC_LOW   3'h3
`define OP_IRQ_ENTRY      3'h4
`define OP_RETURN_IRQ     3'h5
`define OP_TABLE_REG      3'h6
`define OP_TABLE_WORKING  3'h7

// ==========================================================
// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

/* design/program_counter_sequencer.v */
// Program counter sequencing, vectors, lookup reads and register slave of the core
// ==========================================================
`include "pc_seq_map.vh"

module program_counter_sequencer (
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite slave
  input  wire [9:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [9:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Reset sources from outside the domain
  input  wire        power_on_reset,
  input  wire        watchdog_reset,
  input  wire        low_supply_reset,
  // Core events on this clock
  input  wire        sleep_exec,
  input  wire        wdt_clear_exec,
  // Core command port
  input  wire        cmd_valid,
  input  wire [2:0]  cmd_op,
  input  wire [10:0] cmd_target,
  input  wire [7:0]  cmd_data,
  input  wire [8:0]  cmd_file_addr,
  input  wire [7:0]  working_reg,
  output reg         cmd_ready_q,
  // Program flash, one cycle read latency
  output reg  [10:0] flash_addr_q,
  input  wire [15:0] flash_data,
  // Hardware stack
  output reg         stack_push_q,
  output reg  [10:0] stack_push_data_q,
  output reg         stack_pop_q,
  input  wire [10:0] stack_top,
  // Results
  output reg  [10:0] pc_q,
  output reg         gie_q,
  output reg         file_wr_q,
  output reg  [8:0]  file_wr_addr_q,
  output reg  [7:0]  file_wr_data_q,
  output reg         working_wr_q,
  output reg  [7:0]  working_wr_data_q,
  output reg         power_down_flag_q,
  output reg         time_out_flag_q
);

  // ==========================================================
  // Reset sources
  localparam ST_RUN     = 3'b001;
  localparam ST_READ    = 3'b010;
  localparam ST_CAPTURE = 3'b100;

  wire por_s;
  wire wdt_s;
  wire lvr_s;
  reg  por_d1_q;
  reg  wdt_d1_q;
  reg  lvr_d1_q;

  level_sync #(.RESET_LEVEL(1'b0)) u_sync_por (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (power_on_reset),
    .sync_out (por_s)
  );
  level_sync #(.RESET_LEVEL(1'b0)) u_sync_wdt (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (watchdog_reset),
    .sync_out (wdt_s)
  );
  level_sync #(.RESET_LEVEL(1'b0)) u_sync_lvr (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (low_supply_reset),
    .sync_out (lvr_s)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      por_d1_q <= 1'b0;
      wdt_d1_q <= 1'b0;
      lvr_d1_q <= 1'b0;
    end else begin
      por_d1_q <= por_s;
      wdt_d1_q <= wdt_s;
      lvr_d1_q <= lvr_s;
    end
  end

  wire por_evt = por_s & ~por_d1_q;
  wire wdt_evt = wdt_s & ~wdt_d1_q;
  wire lvr_evt = lvr_s & ~lvr_d1_q;
  // A held source keeps the core in reset for as long as it stands
  wire sys_rst = por_s | wdt_s | lvr_s;

  // ==========================================================
  // Status flags and reset cause
  reg [2:0] cause_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      power_down_flag_q <= 1'b1;
      time_out_flag_q   <= 1'b1;
      cause_q           <= `CAUSE_POWER_ON;
    end else if (por_evt) begin
      power_down_flag_q <= 1'b1;
      time_out_flag_q   <= 1'b1;
      cause_q           <= `CAUSE_POWER_ON;
    end else if (lvr_evt) begin
      power_down_flag_q <= 1'b1;
      time_out_flag_q   <= 1'b1;
      cause_q           <= `CAUSE_LOW_SUPPLY;
    end else if (wdt_evt) begin
      power_down_flag_q <= 1'b1;
      time_out_flag_q   <= 1'b0;
      cause_q           <= `CAUSE_WATCHDOG;
    end else if (wdt_clear_exec) begin
      power_down_flag_q <= 1'b1;
      time_out_flag_q   <= 1'b1;
    end else if (sleep_exec) begin
      power_down_flag_q <= 1'b0;
      time_out_flag_q   <= 1'b1;
    end
  end

  // ==========================================================
  // Register bus decode
  reg        aw_have_q;
  reg        w_have_q;
  reg [7:0]  aw_idx_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  reg [7:0]  ptr_low_q;
  reg [7:0]  ptr_high_q;
  reg [7:0]  table_data_high_q;
  reg [2:0]  pc_latch_q;

  wire wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire wr_lo   = wr_fire & w_strb_q[0];
  wire wr_ptr_low  = wr_lo & (aw_idx_q == `IDX_TABLE_POINTER_LOW);
  wire wr_ptr_high = wr_lo & (aw_idx_q == `IDX_TABLE_POINTER_HIGH);
  wire wr_latch    = wr_lo & (aw_idx_q == `IDX_PC_HIGH_LATCH);
  wire wr_ctrl     = wr_lo & (aw_idx_q == `IDX_CONTROL);

  reg wr_mapped;
  always @* begin
    if (aw_idx_q == `IDX_TABLE_POINTER_LOW) begin
      wr_mapped = 1'b1;
    end else if (aw_idx_q == `IDX_TABLE_POINTER_HIGH) begin
      wr_mapped = 1'b1;
    end else if (aw_idx_q == `IDX_PC_HIGH_LATCH) begin
      wr_mapped = 1'b1;
    end else if (aw_idx_q == `IDX_CONTROL) begin
      wr_mapped = 1'b1;
    end else if (aw_idx_q == `IDX_TABLE_DATA_HIGH) begin
      wr_mapped = 1'b1;
    end else if (aw_idx_q == `IDX_PC_LOW_BYTE) begin
      wr_mapped = 1'b1;
    end else if (aw_idx_q == `IDX_STATUS) begin
      wr_mapped = 1'b1;
    end else begin
      wr_mapped = 1'b0;
    end
  end

  // Address and data may arrive in either order; each is held until both are in
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_idx_q      <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_have_q & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready  <= ~w_have_q & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  reg [31:0] rd_word;
  reg        rd_mapped;
  always @* begin
    rd_word   = 32'h0000_0000;
    rd_mapped = 1'b1;
    if (s_axi_araddr[9:2] == `IDX_TABLE_POINTER_LOW) begin
      rd_word[7:0] = ptr_low_q;
    end else if (s_axi_araddr[9:2] == `IDX_TABLE_POINTER_HIGH) begin
      rd_word[7:0] = ptr_high_q;
    end else if (s_axi_araddr[9:2] == `IDX_TABLE_DATA_HIGH) begin
      rd_word[7:0] = table_data_high_q;
    end else if (s_axi_araddr[9:2] == `IDX_PC_HIGH_LATCH) begin
      rd_word[2:0] = pc_latch_q;
    end else if (s_axi_araddr[9:2] == `IDX_PC_LOW_BYTE) begin
      rd_word[7:0] = pc_q[7:0];
    end else if (s_axi_araddr[9:2] == `IDX_STATUS) begin
      rd_word[`STAT_TO_BIT] = time_out_flag_q;
      rd_word[`STAT_PD_BIT] = power_down_flag_q;
      rd_word[`STAT_CAUSE_MSB:`STAT_CAUSE_LSB] = cause_q;
      rd_word[`STAT_PC_MSB:`STAT_PC_LSB] = pc_q;
    end else if (s_axi_araddr[9:2] == `IDX_CONTROL) begin
      rd_word[`CTRL_GIE_BIT] = gie_q;
    end else begin
      rd_mapped = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Sequencer
  reg [2:0]  state_q;
  reg        tbl_to_working_q;
  reg [8:0]  tbl_file_q;
  wire       take   = cmd_valid & cmd_ready_q & (state_q == ST_RUN);
  wire [10:0] pc_next = (pc_q == `PC_LAST_WORD) ? `PC_RESET_VECTOR : pc_q + 11'h001;
  // Carry out of the low byte is dropped on purpose; jump tables stay in one page
  wire [7:0] low_sum = pc_next[7:0] + working_reg;
  wire       irq_ok  = take & (cmd_op == `OP_IRQ_ENTRY) & gie_q;

  always @(posedge aclk) begin
    if (!aresetn || sys_rst) begin
      pc_q              <= `PC_RESET_VECTOR;
      flash_addr_q      <= `PC_RESET_VECTOR;
      state_q           <= ST_RUN;
      cmd_ready_q       <= 1'b0;
      ptr_low_q         <= `PTR_RESET;
      ptr_high_q        <= `PTR_RESET;
      table_data_high_q <= `PTR_RESET;
      pc_latch_q        <= `LATCH_RESET;
      gie_q             <= 1'b0;
      tbl_to_working_q  <= 1'b0;
      tbl_file_q        <= 9'h000;
      stack_push_q      <= 1'b0;
      stack_push_data_q <= `PC_RESET_VECTOR;
      stack_pop_q       <= 1'b0;
      file_wr_q         <= 1'b0;
      file_wr_addr_q    <= 9'h000;
      file_wr_data_q    <= 8'h00;
      working_wr_q      <= 1'b0;
      working_wr_data_q <= 8'h00;
    end else begin
      stack_push_q <= 1'b0;
      stack_pop_q  <= 1'b0;
      file_wr_q    <= 1'b0;
      working_wr_q <= 1'b0;
      if (wr_ptr_low) begin
        ptr_low_q <= w_data_q[7:0];
      end
      if (wr_ptr_high) begin
        ptr_high_q <= w_data_q[7:0];
      end
      if (wr_latch) begin
        pc_latch_q <= w_data_q[2:0];
      end
      // Hardware set and clear of the enable win over a same-cycle software write
      if (irq_ok) begin
        gie_q <= 1'b0;
      end else if (take && cmd_op == `OP_RETURN_IRQ) begin
        gie_q <= 1'b1;
      end else if (wr_ctrl) begin
        gie_q <= w_data_q[`CTRL_GIE_BIT];
      end
      case (state_q)
        ST_RUN: begin
          cmd_ready_q  <= 1'b1;
          flash_addr_q <= pc_q;
          if (take) begin
            case (cmd_op)
              `OP_JUMP: begin
                pc_q         <= cmd_target;
                flash_addr_q <= cmd_target;
              end
              `OP_ADD_PC_LOW: begin
                pc_q         <= {pc_latch_q, low_sum};
                flash_addr_q <= {pc_latch_q, low_sum};
              end
              `OP_WRITE_PC_LOW: begin
                pc_q         <= {pc_latch_q, cmd_data};
                flash_addr_q <= {pc_latch_q, cmd_data};
              end
              `OP_IRQ_ENTRY: begin
                // Only the counter is saved; working and status stay untouched
                if (gie_q) begin
                  stack_push_q      <= 1'b1;
                  stack_push_data_q <= pc_q;
                  pc_q              <= `PC_IRQ_VECTOR;
                  flash_addr_q      <= `PC_IRQ_VECTOR;
                end
              end
              `OP_RETURN_IRQ: begin
                stack_pop_q  <= 1'b1;
                pc_q         <= stack_top;
                flash_addr_q <= stack_top;
              end
              `OP_TABLE_REG, `OP_TABLE_WORKING: begin
                // Flash port is borrowed for two cycles, so the command port stalls
                pc_q             <= pc_next;
                flash_addr_q     <= {ptr_high_q[2:0], ptr_low_q};
                tbl_to_working_q <= (cmd_op == `OP_TABLE_WORKING);
                tbl_file_q       <= cmd_file_addr;
                cmd_ready_q      <= 1'b0;
                state_q          <= ST_READ;
              end
              default: begin
                pc_q         <= pc_next;
                flash_addr_q <= pc_next;
              end
            endcase
          end
        end
        ST_READ: begin
          state_q <= ST_CAPTURE;
        end
        ST_CAPTURE: begin
          table_data_high_q <= flash_data[15:8];
          if (tbl_to_working_q) begin
            working_wr_q      <= 1'b1;
            working_wr_data_q <= flash_data[7:0];
          end else begin
            file_wr_q      <= 1'b1;
            file_wr_addr_q <= tbl_file_q;
            file_wr_data_q <= flash_data[7:0];
          end
          flash_addr_q <= pc_q;
          cmd_ready_q  <= 1'b1;
          state_q      <= ST_RUN;
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

endmodule

/* tb/flash_stack_model.sv */
// Program flash and hardware stack on the sequencer's far side
module flash_stack_model (
  input  wire         aclk,
  input  wire  [10:0] flash_addr_q,
  output logic [15:0] flash_data,
  input  wire         stack_push_q,
  input  wire  [10:0] stack_push_data_q,
  input  wire         stack_pop_q,
  output logic [10:0] stack_top
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] stack_mem [0:7];
  logic [2:0]  depth_q = 3'h0;
  // Bytes differ so a swapped lane shows up
  function automatic logic [15:0] word_at(input logic [10:0] a);
    return {a[7:0] ^ 8'h5a, a[10:3]};
  endfunction
  always @(posedge aclk) begin
    flash_data <= word_at(flash_addr_q);
    if (stack_push_q === 1'h1) begin
      stack_mem[depth_q] <= stack_push_data_q;
      depth_q <= depth_q + 3'h1;
    end else if (stack_pop_q === 1'h1) begin
      depth_q <= depth_q - 3'h1;
    end
  end
  // Empty stack gives a moving pattern, never a stale entry
  assign stack_top = (depth_q == 3'h0) ? ~flash_addr_q : stack_mem[depth_q - 3'h1];
endmodule

/* tb/pc_seq_properties.sv */
// Port-level concurrent checks for the program counter sequencer
`include "pc_seq_map.vh"
module pc_seq_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        power_on_reset,
  input wire        watchdog_reset,
  input wire        low_supply_reset,
  input wire        sleep_exec,
  input wire        cmd_valid,
  input wire [2:0]  cmd_op,
  input wire [7:0]  cmd_data,
  input wire [8:0]  cmd_file_addr,
  input wire [7:0]  working_reg,
  input wire        cmd_ready_q,
  input wire [15:0] flash_data,
  input wire        stack_push_q,
  input wire [10:0] stack_push_data_q,
  input wire        stack_pop_q,
  input wire [10:0] stack_top,
  input wire [10:0] pc_q,
  input wire        gie_q,
  input wire        file_wr_q,
  input wire [8:0]  file_wr_addr_q,
  input wire [7:0]  file_wr_data_q,
  input wire        working_wr_q,
  input wire [7:0]  working_wr_data_q,
  input wire        power_down_flag_q,
  input wire        time_out_flag_q
);
  timeunit 1ns;
  timeprecision 1ps;
  wire take  = cmd_valid & cmd_ready_q;
  wire quiet = !power_on_reset & !watchdog_reset & !low_supply_reset;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Vectors and counter stepping
  a_reset_pc_zero: assert property (disable iff (1'b0)
    !aresetn |=> pc_q == `PC_RESET_VECTOR) else $error("pc not at reset vector");
  a_advance_wraps: assert property (
    take && cmd_op == `OP_ADVANCE |=> pc_q == $past(pc_q) + 11'h1) else $error("bad step");
  a_irq_vector: assert property (
    take && cmd_op == `OP_IRQ_ENTRY && gie_q |=> pc_q == `PC_IRQ_VECTOR && stack_push_q
    && stack_push_data_q == $past(pc_q) && !gie_q && !working_wr_q) else $error("bad irq");
  a_return_pops: assert property (
    take && cmd_op == `OP_RETURN_IRQ |=> pc_q == $past(stack_top) && stack_pop_q && gie_q)
    else $error("bad return");
  a_add_low_byte: assert property (
    take && cmd_op == `OP_ADD_PC_LOW
    |=> pc_q[7:0] == 8'($past(pc_q) + 11'h1 + $past(working_reg))) else $error("bad add");
  a_write_low_byte: assert property (
    take && cmd_op == `OP_WRITE_PC_LOW |=> pc_q[7:0] == $past(cmd_data))
    else $error("bad low write");
  // ==========================================================
  // Lookup reads: two stalled cycles, then the low byte lands
  a_table_to_file: assert property (
    take && cmd_op == `OP_TABLE_REG |=> !cmd_ready_q [*2] ##1 (file_wr_q
    && file_wr_addr_q == $past(cmd_file_addr, 3) && file_wr_data_q == 8'($past(flash_data))))
    else $error("bad file lookup");
  a_table_to_work: assert property (
    take && cmd_op == `OP_TABLE_WORKING |=> !cmd_ready_q [*2] ##1 (working_wr_q
    && working_wr_data_q == 8'($past(flash_data)))) else $error("bad working lookup");
  // ==========================================================
  // Reset cause flags
  a_wdt_flags: assert property (
    $rose(watchdog_reset) && !power_on_reset && !low_supply_reset
    |-> ##[2:5] (power_down_flag_q && !time_out_flag_q)) else $error("bad watchdog flags");
  a_sleep_flags: assert property (
    sleep_exec && quiet |=> !power_down_flag_q && time_out_flag_q) else $error("bad sleep");
  c_irq: cover property (take && cmd_op == `OP_IRQ_ENTRY && gie_q);
  c_table: cover property (take && cmd_op == `OP_TABLE_REG);
  c_wdt: cover property ($rose(watchdog_reset));
endmodule

bind program_counter_sequencer pc_seq_checker chk_i (.*);

/* tb/program_counter_sequencer_tb.sv */
// Self-checking bench for the program counter sequencer
`include "pc_seq_map.vh"
module program_counter_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, power_on_reset, watchdog_reset, low_supply_reset;
  logic        sleep_exec, wdt_clear_exec, cmd_valid, cmd_ready_q;
  logic [2:0]  cmd_op;
  logic [10:0] cmd_target, flash_addr_q, stack_push_data_q, stack_top, pc_q;
  logic [7:0]  cmd_data, working_reg, file_wr_data_q, working_wr_data_q;
  logic [8:0]  cmd_file_addr, file_wr_addr_q;
  logic [15:0] flash_data, fwv;
  logic        stack_push_q, stack_pop_q, gie_q, file_wr_q, working_wr_q;
  logic        power_down_flag_q, time_out_flag_q;
  int          miscompares, n_compared;
  localparam logic [9:0] TDH = {`IDX_TABLE_DATA_HIGH, 2'h0};
  localparam logic [9:0] PTH = {`IDX_TABLE_POINTER_HIGH, 2'h0};
  localparam logic [9:0] PTL = {`IDX_TABLE_POINTER_LOW, 2'h0};
  localparam logic [9:0] LAT = {`IDX_PC_HIGH_LATCH, 2'h0};

  program_counter_sequencer uut (.*);
  flash_stack_model mdl (.*);

  initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end
  // ==========================================================
  // Shared drivers and comparison
  function automatic logic [15:0] fw(input logic [10:0] a);
    return {a[7:0] ^ 8'h5a, a[10:3]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 50);
    if (s_axi_bvalid !== 1'h1) miscompares++;
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [9:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 50);
    if (s_axi_rvalid !== 1'h1) miscompares++;
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask
  // Returns one edge after the take, when the counter shows the result
  task automatic cmd(input logic [2:0] op, input logic [10:0] tg, input logic [7:0] d);
    int n;
    n = 0;
    cmd_op <= op;
    cmd_target <= tg;
    cmd_data <= d;
    cmd_valid <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
    end while (cmd_ready_q !== 1'h1 && n < 50);
    if (cmd_ready_q !== 1'h1) miscompares++;
    cmd_valid <= 1'h0;
    @(posedge aclk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    chk(pc_q, `PC_RESET_VECTOR);
    chk({power_down_flag_q, time_out_flag_q}, 2'h3);
    rd({`IDX_STATUS, 2'h0});
    chk(rdv[4:0], {`CAUSE_POWER_ON, 2'h3});
  endtask
  task automatic t_table;
    wr(PTH, 32'h6);
    wr(PTL, 32'h2);
    rd(PTH);
    chk(rdv, 32'h6);
    rd(10'h3fc);
    chk(rsp, `RESP_SLVERR);
    chk(rdv, 32'h0);
    fwv = fw(11'h602);
    cmd(`OP_TABLE_REG, 11'h0, 8'h0);
    repeat (2) @(posedge aclk);
    chk({file_wr_q, file_wr_addr_q, file_wr_data_q}, {1'h1, 9'h1a5, fwv[7:0]});
    wr(TDH, 32'hff);
    chk(rsp, `RESP_OKAY);
    rd(TDH);
    chk(rdv, {24'h0, fwv[15:8]});
    // Different high byte from the first lookup, so a missed update shows
    wr(PTL, 32'h13);
    fwv = fw(11'h613);
    cmd(`OP_TABLE_WORKING, 11'h0, 8'h0);
    repeat (2) @(posedge aclk);
    chk({working_wr_q, working_wr_data_q}, {1'h1, fwv[7:0]});
    rd(TDH);
    chk(rdv, {24'h0, fwv[15:8]});
  endtask
  task automatic t_jump;
    wr(LAT, 32'h1);
    cmd(`OP_JUMP, 11'h110, 8'h0);
    working_reg <= 8'h3;
    cmd(`OP_ADD_PC_LOW, 11'h0, 8'h0);
    chk(pc_q, 11'h114);
    wr(LAT, 32'h0);
    cmd(`OP_JUMP, 11'h0fc, 8'h0);
    working_reg <= 8'h5;
    cmd(`OP_ADD_PC_LOW, 11'h0, 8'h0);
    chk(pc_q, 11'h002);
    wr(LAT, 32'h5);
    cmd(`OP_WRITE_PC_LOW, 11'h0, 8'h33);
    chk(pc_q, 11'h533);
    cmd(`OP_JUMP, `PC_LAST_WORD, 8'h0);
    cmd(`OP_ADVANCE, 11'h0, 8'h0);
    chk(pc_q, `PC_RESET_VECTOR);
  endtask
  task automatic t_irq;
    wr({`IDX_CONTROL, 2'h0}, 32'h1);
    cmd(`OP_JUMP, 11'h123, 8'h0);
    cmd(`OP_IRQ_ENTRY, 11'h0, 8'h0);
    chk({pc_q, stack_push_q, stack_push_data_q, gie_q}, {`PC_IRQ_VECTOR, 1'h1, 11'h123, 1'h0});
    chk(working_wr_q, 1'h0);
    cmd(`OP_IRQ_ENTRY, 11'h0, 8'h0);
    chk({pc_q, stack_push_q}, {`PC_IRQ_VECTOR, 1'h0});
    cmd(`OP_RETURN_IRQ, 11'h0, 8'h0);
    chk({pc_q, stack_pop_q, gie_q}, {11'h123, 2'h3});
  endtask
  task automatic t_src;
    logic [2:0] sel [3];
    logic [4:0] exp [3];
    sel = '{3'h4, 3'h2, 3'h1};
    exp = '{{`CAUSE_POWER_ON, 2'h3}, {`CAUSE_WATCHDOG, 2'h2}, {`CAUSE_LOW_SUPPLY, 2'h3}};
    for (int i = 0; i < 3; i++) begin
      sleep_exec <= 1'h1;
      @(posedge aclk);
      sleep_exec <= 1'h0;
      @(posedge aclk);
      chk({power_down_flag_q, time_out_flag_q}, 2'h1);
      cmd(`OP_JUMP, 11'h2aa, 8'h0);
      {power_on_reset, watchdog_reset, low_supply_reset} <= sel[i];
      repeat (6) @(posedge aclk);
      {power_on_reset, watchdog_reset, low_supply_reset} <= 3'h0;
      repeat (6) @(posedge aclk);
      chk(pc_q, `PC_RESET_VECTOR);
      rd({`IDX_STATUS, 2'h0});
      chk(rdv[4:0], exp[i]);
    end
    wdt_clear_exec <= 1'h1;
    @(posedge aclk);
    wdt_clear_exec <= 1'h0;
    @(posedge aclk);
    chk({power_down_flag_q, time_out_flag_q}, 2'h3);
  endtask
  // ==========================================================
  // Sequence, watchdog and verdict
  task automatic final_report;
    if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    miscompares = 0;
    n_compared = 0;
    aresetn = 1'h0;
    {power_on_reset, watchdog_reset, low_supply_reset, sleep_exec, wdt_clear_exec} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {cmd_valid, cmd_op, cmd_target, cmd_data, working_reg} = '0;
    cmd_file_addr = 9'h1a5;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    t_reset;
    t_table;
    t_jump;
    t_irq;
    t_src;
    final_report;
  end
  // Whole run needs about 160 cycles; this allows ample margin
  initial begin
    #40000;
    miscompares++;
    final_report;
  end
endmodule
